// *** jl_pkg.sv ***
/*
  constants for the jumperless set-up, soft-reset window and card attribute decode.
  assumes the pin groups are sampled on one 25 MHz clock.
*/
package jl_pkg;
  // ----------------------------------------
  // system interface modes (strap codes)
  // ----------------------------------------
  localparam logic [1:0] MODE_PCCARD = 2'h0;
  localparam logic [1:0] MODE_ISA = 2'h1;
  localparam logic [1:0] MODE_GENERAL = 2'h2;
  localparam logic [1:0] MODE_NONE = 2'h3;

  // ----------------------------------------
  // isa register offsets (sa4..sa0)
  // ----------------------------------------
  localparam logic [4:0] ADDR_BASE_ADV = 5'h12;
  localparam logic [4:0] ADDR_STATUS = 5'h13;
  localparam logic [1:0] RESET_WIN_TOP = 2'h3;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ADV_READ_DATA = 8'h00;

  // ----------------------------------------
  // status fields
  // ----------------------------------------
  localparam int IRQ_HI = 7;
  localparam int IRQ_LO = 6;
  localparam int BASE_HI = 2;
  localparam logic [2:0] BASE_RESET = 3'h0;
  localparam logic [2:0] BASE_RSVD = 3'h3;
  localparam logic [2:0] UNUSED_BITS = 3'h0;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ----------------------------------------
  // attribute area (a10..a0)
  // ----------------------------------------
  localparam logic [7:0] CCR_PAGE = 8'hfe;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // base select code sequence, reserved code skipped
  function automatic logic [2:0] next_base(input logic [2:0] cur);
    logic [2:0] n;
    n = cur + 3'h1;
    if (n == BASE_RSVD) begin
      n = n + 3'h1;
    end
    return n;
  endfunction
endpackage

// *** jl_sync_if.sv ***
/*
  carrier for pin levels after two-flop synchronisation and their falling edges.
  assumes producer and consumer share one clock.
*/
interface jl_sync_if #(parameter int W = 8);
  logic [W-1:0] level;
  logic [W-1:0] fall;
  modport src(output level, output fall);
  modport dst(input level, input fall);
endinterface

// *** jl_pin_sync.sv ***
/*
  two-flop synchroniser with falling-edge detect for a vector of pins.
  assumes the pins are asynchronous to i_clk; reset is asynchronous, active low.
*/
module jl_pin_sync #(
  parameter int W = 8
) (
  input wire logic i_clk,         // system clock
  input wire logic i_rst_n,       // async reset, active low
  input wire logic [W-1:0] i_pin, // raw pins
  jl_sync_if.src sync             // synchronised levels and edges
);
  logic [W-1:0] meta;
  logic [W-1:0] stage;
  logic [W-1:0] prev;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_stage;
  logic [W-1:0] next_prev;

  always_comb begin
    next_meta = i_pin;
    next_stage = meta;
    next_prev = stage;
  end

  // pins idle high, so reset to ones to avoid a false edge at release
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= '1;
      stage <= '1;
      prev <= '1;
    end else begin
      meta <= next_meta;
      stage <= next_stage;
      prev <= next_prev;
    end
  end

  assign sync.level = stage;
  assign sync.fall = prev & ~stage;
endmodule

// *** jl_setup_regs.sv ***
/*
  jumperless set-up status, base-select advance, isa soft-reset window,
  and pc-card rom upper address and attribute decode.
  assumes straps are static after reset, host strobes are asynchronous pins,
  and the set-up loader supplies the interrupt code on the system clock.
*/
// What this block does
// - an eight-bit set-up status register, all zero after power-on, valid in jumperless mode
// - status bits 7:6 show the chosen interrupt line code
// - any write to the eight reset addresses reinitialises the lan core
// - that write resets internal registers but keeps base code and status
// - the reset addresses act only in isa bus mode
// - in pc card mode drive the rom upper address for id i/o reads
// - in pc card mode decode a10..a0 for card data and 7f0h-7f6h config regs
// - each read of the advance register steps the base code in jumperless mode
module jl_setup_regs (
  input wire logic I_CLK,             // 25 MHz system clock
  input wire logic I_RST_N,           // power-on reset, async, active low
  input wire logic [1:0] I_MODE,      // system interface mode strap
  input wire logic I_JUMPERLESS,      // jumperless strap, high = jumperless
  input wire logic I_CS_N,            // card/io select pin, active low
  input wire logic I_IOR_N,           // i/o read strobe pin, active low
  input wire logic I_IOW_N,           // i/o write strobe pin, active low
  input wire logic [4:0] I_SA,        // isa register address pins
  input wire logic I_REG_N,           // attribute space select pin, active low
  input wire logic [10:0] I_PA,       // card address pins a10..a0
  input wire logic I_IRQ_LOAD,        // set-up loader strobe, one cycle
  input wire logic [1:0] I_IRQ_CODE,  // interrupt line code from the loader
  output logic [7:0] O_SD,            // read data to the host bus
  output logic O_SD_OE_N,             // data output enable, low while driving
  output logic O_CORE_INIT,           // one-cycle lan core reinit pulse
  output logic O_REG_INIT,            // one-cycle internal register reset pulse
  output logic O_ROM_UPPER,           // rom upper address line
  output logic O_CIS_SEL,             // card attribute data select
  output logic [3:0] O_CCR_SEL,       // config register selects 7f0h..7f6h
  output logic [7:0] O_STATUS         // set-up status view
);
  // ----------------------------------------
  // pin synchronisation
  // ----------------------------------------
  // vector width and strobe positions follow the concatenation order below
  localparam int PW = $bits({I_MODE, I_JUMPERLESS, I_CS_N, I_IOR_N, I_IOW_N, I_SA, I_REG_N, I_PA});
  localparam int IOW_BIT = $bits({I_SA, I_REG_N, I_PA});
  localparam int IOR_BIT = $bits({I_IOW_N, I_SA, I_REG_N, I_PA});
  jl_sync_if #(.W(PW)) pins();

  jl_pin_sync #(.W(PW)) u_sync (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_pin({I_MODE, I_JUMPERLESS, I_CS_N, I_IOR_N, I_IOW_N, I_SA, I_REG_N, I_PA}),
    .sync(pins)
  );

  logic [1:0] s_mode;
  logic s_jl;
  logic s_cs_n;
  logic s_ior_n;
  logic s_iow_n;
  logic [4:0] s_sa;
  logic s_reg_n;
  logic [10:0] s_pa;
  logic ior_fall;
  logic iow_fall;

  assign {s_mode, s_jl, s_cs_n, s_ior_n, s_iow_n, s_sa, s_reg_n, s_pa} = pins.level;
  assign ior_fall = pins.fall[IOR_BIT];
  assign iow_fall = pins.fall[IOW_BIT];

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  // straps are taken a few cycles after release so the synchroniser has settled
  logic [1:0] strap_cnt;
  logic [1:0] mode;
  logic jl;
  logic [1:0] next_strap_cnt;
  logic [1:0] next_mode;
  logic next_jl;

  always_comb begin
    next_strap_cnt = strap_cnt;
    next_mode = mode;
    next_jl = jl;
    if (strap_cnt != jl_pkg::STRAP_WAIT) begin
      next_strap_cnt = strap_cnt + 2'h1;
      if (next_strap_cnt == jl_pkg::STRAP_WAIT) begin
        next_mode = s_mode;
        next_jl = s_jl;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      strap_cnt <= 2'h0;
      mode <= jl_pkg::MODE_NONE;
      jl <= 1'b0;
    end else begin
      strap_cnt <= next_strap_cnt;
      mode <= next_mode;
      jl <= next_jl;
    end
  end

  // ----------------------------------------
  // host access decode
  // ----------------------------------------
  logic is_isa;
  logic is_card;
  logic adv_hit;
  logic rst_hit;
  logic rd_status;
  logic rd_adv;

  assign is_isa = (mode == jl_pkg::MODE_ISA);
  assign is_card = (mode == jl_pkg::MODE_PCCARD);
  assign adv_hit = ior_fall && !s_cs_n && is_isa && jl && (s_sa == jl_pkg::ADDR_BASE_ADV);
  assign rst_hit = iow_fall && !s_cs_n && is_isa && (s_sa[4:3] == jl_pkg::RESET_WIN_TOP);
  assign rd_status = !s_ior_n && !s_cs_n && is_isa && (s_sa == jl_pkg::ADDR_STATUS);
  assign rd_adv = !s_ior_n && !s_cs_n && is_isa && (s_sa == jl_pkg::ADDR_BASE_ADV);

  // ----------------------------------------
  // set-up state and outputs
  // ----------------------------------------
  logic [2:0] base;
  logic [1:0] irq;
  logic [7:0] status;
  logic [2:0] next_base;
  logic [1:0] next_irq;
  logic [7:0] next_sd;
  logic next_sd_oe_n;
  logic next_core_init;
  logic next_rom_upper;
  logic next_cis_sel;
  logic [3:0] next_ccr_sel;

  // status has no write path at all, so host writes to it fall through
  assign status = {irq, jl_pkg::UNUSED_BITS, base};

  always_comb begin
    next_base = base;
    next_irq = irq;
    if (adv_hit) begin
      next_base = jl_pkg::next_base(base);
    end
    if (I_IRQ_LOAD && jl) begin
      next_irq = I_IRQ_CODE;
    end
    // soft reset leaves base and irq alone
    next_core_init = rst_hit;
    next_sd_oe_n = !(rd_status || rd_adv);
    next_sd = rd_status ? status : jl_pkg::ADV_READ_DATA;
    // id i/o reads take the upper rom half; attribute reads keep it low
    next_rom_upper = is_card && !s_cs_n && !s_ior_n && s_reg_n;
    next_cis_sel = 1'b0;
    next_ccr_sel = 4'h0;
    if (is_card && !s_cs_n && !s_reg_n && !s_pa[0]) begin
      if (s_pa[10:3] == jl_pkg::CCR_PAGE) begin
        next_ccr_sel = 4'h1 << s_pa[2:1];
      end else if (s_pa[10:3] < jl_pkg::CCR_PAGE) begin
        next_cis_sel = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      base <= jl_pkg::BASE_RESET;
      irq <= jl_pkg::IRQ_RESET;
      O_SD <= jl_pkg::STATUS_RESET;
      O_SD_OE_N <= 1'b1;
      O_CORE_INIT <= 1'b0;
      O_REG_INIT <= 1'b0;
      O_ROM_UPPER <= 1'b0;
      O_CIS_SEL <= 1'b0;
      O_CCR_SEL <= 4'h0;
      O_STATUS <= jl_pkg::STATUS_RESET;
    end else begin
      base <= next_base;
      irq <= next_irq;
      O_SD <= next_sd;
      O_SD_OE_N <= next_sd_oe_n;
      O_CORE_INIT <= next_core_init;
      O_REG_INIT <= next_core_init;
      O_ROM_UPPER <= next_rom_upper;
      O_CIS_SEL <= next_cis_sel;
      O_CCR_SEL <= next_ccr_sel;
      O_STATUS <= {next_irq, jl_pkg::UNUSED_BITS, next_base};
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_reset_write;
    rst_hit;
  endsequence

  sequence s_init_pulse;
    O_CORE_INIT && O_REG_INIT ##1 !O_CORE_INIT;
  endsequence

  property p_status_view;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (!O_SD_OE_N && $past(rd_status)) |-> (O_SD == O_STATUS) && (O_SD[5:3] == jl_pkg::UNUSED_BITS);
  endproperty
  a_status_view: assert property (p_status_view) else $error("status read data wrong");

  localparam int IRQ_HI_I = jl_pkg::IRQ_HI;
  localparam int IRQ_LO_I = jl_pkg::IRQ_LO;
  property p_irq_load;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (I_IRQ_LOAD && jl) |=> (O_STATUS[IRQ_HI_I:IRQ_LO_I] == $past(I_IRQ_CODE));
  endproperty
  a_irq_load: assert property (p_irq_load) else $error("interrupt code not shown");

  property p_core_init;
    @(posedge I_CLK) disable iff (!I_RST_N)
      s_reset_write |=> s_init_pulse;
  endproperty
  a_core_init: assert property (p_core_init) else $error("reset write gave no init pulse");

  property p_keep_setup;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (rst_hit && !adv_hit && !I_IRQ_LOAD) |=> $stable(O_STATUS);
  endproperty
  a_keep_setup: assert property (p_keep_setup) else $error("soft reset disturbed set-up");

  property p_isa_only;
    @(posedge I_CLK) disable iff (!I_RST_N)
      O_CORE_INIT |-> $past(mode) == jl_pkg::MODE_ISA;
  endproperty
  a_isa_only: assert property (p_isa_only) else $error("init outside isa mode");

  property p_rom_upper;
    @(posedge I_CLK) disable iff (!I_RST_N)
      O_ROM_UPPER |-> mode == jl_pkg::MODE_PCCARD && !O_CIS_SEL && O_CCR_SEL == 4'h0;
  endproperty
  a_rom_upper: assert property (p_rom_upper) else $error("rom upper outside card id read");

  property p_ccr_decode;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (O_CCR_SEL != 4'h0) |-> $onehot(O_CCR_SEL) && !O_CIS_SEL && $past(s_pa[10:3]) == jl_pkg::CCR_PAGE;
  endproperty
  a_ccr_decode: assert property (p_ccr_decode) else $error("config register decode wrong");

  property p_advance;
    @(posedge I_CLK) disable iff (!I_RST_N)
      adv_hit |=> base == jl_pkg::next_base($past(base)) && base != jl_pkg::BASE_RSVD;
  endproperty
  a_advance: assert property (p_advance) else $error("base code did not step");

  property p_base_stable;
    @(posedge I_CLK) disable iff (!I_RST_N)
      !adv_hit |=> $stable(base);
  endproperty
  a_base_stable: assert property (p_base_stable) else $error("base code moved without a read");
endmodule

// *** jl_host_model.sv ***
/*
  host model: drives select, strobes and address pins of the isa / pc-card bus and captures each answer.
  assumes one 25 MHz clock shared with the device; pins change 1 ns after a rising edge.
*/
module jl_host_model (
  input wire logic i_clk,           // system clock
  input wire logic [7:0] i_sd,      // read data from the device
  input wire logic i_sd_oe_n,       // device data enable, active low
  input wire logic i_rom_upper,     // rom upper address from the device
  input wire logic i_cis_sel,       // attribute data select
  input wire logic [3:0] i_ccr_sel, // config register selects
  output logic o_cs_n,              // select, active low
  output logic o_ior_n,             // read strobe, active low
  output logic o_iow_n,             // write strobe, active low
  output logic [4:0] o_sa,          // register address
  output logic o_reg_n,             // attribute space select, active low
  output logic [10:0] o_pa          // card address
);
  logic [7:0] sd;
  logic oe_n;
  logic rom;
  logic card_attribute_data;
  logic [3:0] card_config_regs;

  initial begin
    o_cs_n = 1'b1;
    o_ior_n = 1'b1;
    o_iow_n = 1'b1;
    o_sa = 5'h00;
    o_reg_n = 1'b1;
    o_pa = 11'h000;
  end

  // ----------------------------------------
  // one strobed access
  // ----------------------------------------
  // address settles two cycles before the strobe; strobe stays low four cycles,
  // comfortably above the two-cycle minimum the synchroniser needs
  task automatic access(input logic wr, input logic reg_n, input logic [10:0] addr);
    o_cs_n = 1'b0;
    o_reg_n = reg_n;
    o_sa = addr[4:0];
    o_pa = addr;
    repeat (2) @(posedge i_clk);
    #1;
    if (wr) begin
      o_iow_n = 1'b0;
    end else begin
      o_ior_n = 1'b0;
    end
    repeat (4) @(posedge i_clk);
    #1;
    sd = i_sd;
    oe_n = i_sd_oe_n;
    rom = i_rom_upper;
    card_attribute_data = i_cis_sel;
    card_config_regs = i_ccr_sel;
    o_ior_n = 1'b1;
    o_iow_n = 1'b1;
    o_cs_n = 1'b1;
    o_reg_n = 1'b1;
    // released address lines must not keep the last value
    o_sa = ~o_sa;
    o_pa = ~o_pa;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
endmodule

// *** jl_setup_regs_test.sv ***
/*
  self-checking bench for the jumperless set-up status, soft-reset window and card decode.
  assumes the host model file is compiled first; straps change only under reset.
*/
module jl_setup_regs_test;
  timeunit 1ns;
  timeprecision 1ps;

  `define CHK(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

  logic I_CLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic [1:0] I_MODE = jl_pkg::MODE_ISA;
  logic I_JUMPERLESS = 1'b1;
  logic I_IRQ_LOAD = 1'b0;
  logic [1:0] I_IRQ_CODE = 2'h0;
  wire logic I_CS_N, I_IOR_N, I_IOW_N, I_REG_N, O_SD_OE_N, O_CORE_INIT, O_REG_INIT, O_ROM_UPPER, O_CIS_SEL;
  wire logic [4:0] I_SA;
  wire logic [10:0] I_PA;
  wire logic [7:0] O_SD, O_STATUS;
  wire logic [3:0] O_CCR_SEL;
  int mismatches = 0;
  int compares = 0;
  int n_core = 0;
  int n_reg = 0;
  logic [2:0] seq [8] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h1};
  logic [1:0] other [3] = '{jl_pkg::MODE_PCCARD, jl_pkg::MODE_GENERAL, jl_pkg::MODE_NONE};

  always #20 I_CLK = ~I_CLK;

  always @(posedge I_CLK) begin
    if (O_CORE_INIT === 1'b1) n_core++;
    if (O_REG_INIT === 1'b1) n_reg++;
  end

  jl_setup_regs dut_u (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_MODE(I_MODE), .I_JUMPERLESS(I_JUMPERLESS),
    .I_CS_N(I_CS_N), .I_IOR_N(I_IOR_N), .I_IOW_N(I_IOW_N), .I_SA(I_SA), .I_REG_N(I_REG_N), .I_PA(I_PA),
    .I_IRQ_LOAD(I_IRQ_LOAD), .I_IRQ_CODE(I_IRQ_CODE), .O_SD(O_SD), .O_SD_OE_N(O_SD_OE_N),
    .O_CORE_INIT(O_CORE_INIT), .O_REG_INIT(O_REG_INIT), .O_ROM_UPPER(O_ROM_UPPER),
    .O_CIS_SEL(O_CIS_SEL), .O_CCR_SEL(O_CCR_SEL), .O_STATUS(O_STATUS));

  jl_host_model host_u (.i_clk(I_CLK), .i_sd(O_SD), .i_sd_oe_n(O_SD_OE_N), .i_rom_upper(O_ROM_UPPER),
    .i_cis_sel(O_CIS_SEL), .i_ccr_sel(O_CCR_SEL), .o_cs_n(I_CS_N), .o_ior_n(I_IOR_N), .o_iow_n(I_IOW_N),
    .o_sa(I_SA), .o_reg_n(I_REG_N), .o_pa(I_PA));

  task automatic do_reset(input logic [1:0] mode, input logic jl);
    I_RST_N = 1'b0;
    I_MODE = mode;
    I_JUMPERLESS = jl;
    repeat (20) @(posedge I_CLK);
    #1;
    I_RST_N = 1'b1;
    repeat (5) @(posedge I_CLK);
    #1;
  endtask

  task automatic load_irq(input logic [1:0] code);
    I_IRQ_CODE = code;
    I_IRQ_LOAD = 1'b1;
    @(posedge I_CLK);
    #1;
    I_IRQ_LOAD = 1'b0;
    repeat (2) @(posedge I_CLK);
    #1;
  endtask

  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    #2000000;
    mismatches++;
    give_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    do_reset(jl_pkg::MODE_ISA, 1'b1);
    `CHK(O_STATUS, 8'h00)
    `CHK(O_SD_OE_N, 1'b1)
    for (int i = 0; i < 4; i++) begin
      load_irq(i[1:0]);
      `CHK(O_STATUS[7:6], i[1:0])
    end
    for (int i = 0; i < 8; i++) begin
      host_u.access(1'b0, 1'b1, 11'h012);
      `CHK(host_u.sd, jl_pkg::ADV_READ_DATA)
      `CHK(host_u.oe_n, 1'b0)
      `CHK(O_STATUS, {2'h3, 3'h0, seq[i]})
    end
    host_u.access(1'b0, 1'b1, 11'h013);
    `CHK(host_u.sd, 8'hc1)
    host_u.access(1'b1, 1'b1, 11'h013);
    `CHK(O_STATUS, 8'hc1)
    // 17h sits just below the window and must not reset anything
    for (int i = 0; i < 9; i++) begin
      n_core = 0;
      n_reg = 0;
      host_u.access(1'b1, 1'b1, 11'h017 + 11'(i));
      `CHK(n_core, int'(i > 0))
      `CHK(n_reg, int'(i > 0))
      `CHK(O_STATUS, 8'hc1)
    end
    do_reset(jl_pkg::MODE_ISA, 1'b0);
    load_irq(2'h3);
    host_u.access(1'b0, 1'b1, 11'h012);
    `CHK(O_STATUS, 8'h00)
    for (int m = 0; m < 3; m++) begin
      do_reset(other[m], 1'b1);
      n_core = 0;
      host_u.access(1'b1, 1'b1, 11'h01c);
      `CHK(n_core, 0)
    end
    // last reset left pc card mode off; bring it back for the card decode
    do_reset(jl_pkg::MODE_PCCARD, 1'b0);
    host_u.access(1'b0, 1'b1, 11'h000);
    `CHK(host_u.rom, 1'b1)
    for (int i = 0; i < 4; i++) begin
      host_u.access(1'b0, 1'b0, 11'h7f0 + 11'(2 * i));
      `CHK(host_u.card_config_regs, 4'h1 << i)
      `CHK(host_u.card_attribute_data, 1'b0)
      `CHK(host_u.rom, 1'b0)
    end
    host_u.access(1'b0, 1'b0, 11'h000);
    `CHK(host_u.card_attribute_data, 1'b1)
    host_u.access(1'b0, 1'b0, 11'h7ee);
    `CHK(host_u.card_attribute_data, 1'b1)
    `CHK(host_u.card_config_regs, 4'h0)
    give_verdict();
  end
endmodule
